// file: kul_defines.svh
// Constants for the key-use limit and copy policy block
`ifndef KUL_DEFINES_SVH
`define KUL_DEFINES_SVH
`define KUL_BITMAP_FULL 8'hFF
`define KUL_BITMAP_EMPTY 8'h00
`define KUL_WRPOL_DERIVE_BIT 13
`define KUL_LIMITED_SLOT 4'hF
`define KUL_TRANSPORT_MIN 16'h8000
`define KUL_MODE_COPY_A 8'h01
`define KUL_MODE_COPY_B 8'h05
`define KUL_MODE_ORIGIN_BIT 2
`define KUL_S15_BYTES 16
`define KUL_S15_BITS 128
`define KUL_REG_CTRL 4'h0
`define KUL_REG_S15_LO 4'h1
`define KUL_REG_S15_HI 4'h2
`define KUL_REG_STATUS 4'h3
`define KUL_REG_SCRATCH 4'h4
`define KUL_REG_USES 4'h5
`define KUL_REG_POLICY 4'h6
`define KUL_RESP_LAT 1
`endif

// file: kul_pkg.sv
// Types for the key-use limit and copy policy block
package kul_pkg;
  typedef enum logic [2:0] {
    KUL_CMD_MAC = 3'h0,
    KUL_CMD_READ = 3'h1,
    KUL_CMD_WRITE = 3'h2,
    KUL_CMD_DERIVE = 3'h3,
    KUL_CMD_VERIFY = 3'h4,
    KUL_CMD_DIGEST = 3'h5
  } kul_cmd_t;

  typedef enum logic [1:0] {
    KUL_ST_IDLE = 2'h0,
    KUL_ST_WAIT = 2'h1
  } kul_state_t;

  typedef struct packed {
    logic origin;
    logic data_cmd_origin;
    logic verify_restrict;
    logic valid;
  } kul_scratch_t;

  typedef struct packed {
    logic ok;
    logic err;
    logic transport;
    logic copy;
    logic [3:0] key_slot;
    logic [15:0] hash_selector;
  } kul_result_t;

  typedef struct packed {
    kul_state_t state;
    logic [7:0][7:0] remaining_uses_bitmap;
    logic [127:0] slot15_use_bitmap;
    logic [7:0] one_shot_enable;
    logic one_shot_enable_15;
    logic [15:0] slot_write_policy;
    logic [15:0] read_auth_zero;
    kul_scratch_t scratch_digest_reg;
    logic [3:0] pend_target;
    logic pend_copy;
    logic pend_derive;
    kul_result_t result;
    logic done;
    logic [31:0] rdata;
    logic [7:0] last_err;
  } kul_state_all_t;
endpackage

// file: kul_policy.sv
// Key-use limit, derivation policy and verify-copy control
//
// The address map and strobed register access were decided locally.
`include "kul_defines.svh"
module kul_policy (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CMD_VALID_IN,
  input wire kul_pkg::kul_cmd_t CMD_IN,
  input wire logic [15:0] SELECTOR_IN,
  input wire logic [3:0] TARGET_IN,
  input wire logic PARENT_USED_IN,
  input wire logic [7:0] MODE_IN,
  input wire logic SECONDARY_IN,
  input wire logic HASH_DONE_IN,
  input wire logic RESP_MATCH_IN,
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic RESULT_VALID_OUT,
  output logic RESULT_OK_OUT,
  output logic RESULT_ERR_OUT,
  output logic HASH_START_OUT,
  output logic TRANSPORT_OUT,
  output logic [3:0] KEY_SLOT_OUT,
  output logic [15:0] HASH_SELECTOR_OUT,
  output logic COPY_LOAD_OUT,
  output logic [3:0] COPY_SLOT_OUT,
  output logic [3:0] SCRATCH_FLAGS_OUT
);
  // ------------------------------
  // Helpers
  // ------------------------------
  // Clear the first set bit from the top, used for the 8-bit use bitmaps only
  function automatic logic [7:0] kul_clear_first8(input logic [7:0] b);
    logic found;
    logic [7:0] r;
    found = 1'b0;
    r = b;
    for (int i = 7; i >= 0; i--) begin
      if (!found && b[i]) begin
        r[i] = 1'b0;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  // Byte 0 is the first bitmap byte, held in bits 127:120
  function automatic logic [127:0] kul_clear_first128(input logic [127:0] b);
    logic found;
    logic [127:0] r;
    found = 1'b0;
    r = b;
    for (int i = 127; i >= 0; i--) begin
      if (!found && b[i]) begin
        r[i] = 1'b0;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  kul_pkg::kul_state_all_t s_reg;
  kul_pkg::kul_state_all_t s_next;

  // ------------------------------
  // Next state
  // ------------------------------
  always_comb begin
    logic [3:0] slot;
    logic [3:0] tgt;
    logic transport;
    logic limited_lo;
    logic limited_15;
    logic fail;
    logic copy_ok;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.result.ok = 1'b0;
    s_next.result.err = 1'b0;
    slot = SELECTOR_IN[3:0];
    transport = SELECTOR_IN >= `KUL_TRANSPORT_MIN;
    limited_lo = !slot[3] && s_reg.one_shot_enable[slot[2:0]];
    limited_15 = (slot == `KUL_LIMITED_SLOT) && s_reg.one_shot_enable_15;
    tgt = SECONDARY_IN ? (slot + 4'h1) : slot;
    fail = 1'b0;
    copy_ok = 1'b0;
    unique case (s_reg.state)
      kul_pkg::KUL_ST_IDLE: begin
        if (CMD_VALID_IN) begin
          s_next.result.transport = transport;
          s_next.result.key_slot = slot;
          s_next.result.hash_selector = SELECTOR_IN;
          s_next.result.copy = 1'b0;
          s_next.pend_derive = 1'b0;
          s_next.pend_copy = 1'b0;
          s_next.pend_target = tgt;
          // Transport keys need a generator-made nonce in scratch
          if (transport && (CMD_IN != kul_pkg::KUL_CMD_DIGEST || s_reg.scratch_digest_reg.origin)) begin
            fail = 1'b1;
          end else if (CMD_IN == kul_pkg::KUL_CMD_READ || CMD_IN == kul_pkg::KUL_CMD_WRITE) begin
            fail = 1'b0;
          end else if (CMD_IN == kul_pkg::KUL_CMD_VERIFY) begin
            // Copy path ignores one-shot limits entirely
            copy_ok = (MODE_IN == `KUL_MODE_COPY_A || MODE_IN == `KUL_MODE_COPY_B)
              && (s_reg.scratch_digest_reg.origin == MODE_IN[`KUL_MODE_ORIGIN_BIT])
              && s_reg.read_auth_zero[tgt];
            s_next.pend_copy = copy_ok;
            s_next.result.copy = copy_ok;
          end else if (CMD_IN == kul_pkg::KUL_CMD_DERIVE) begin
            if (!s_reg.slot_write_policy[TARGET_IN]) begin
              fail = 1'b1;
            end else if (PARENT_USED_IN && limited_lo
                && s_reg.remaining_uses_bitmap[slot[2:0]] == `KUL_BITMAP_EMPTY) begin
              fail = 1'b1;
            end else if (PARENT_USED_IN && limited_15 && s_reg.slot15_use_bitmap == '0) begin
              fail = 1'b1;
            end
            s_next.pend_derive = 1'b1;
            s_next.pend_target = TARGET_IN;
          end else if (limited_15) begin
            fail = s_reg.slot15_use_bitmap == '0;
          end else if (limited_lo) begin
            fail = s_reg.remaining_uses_bitmap[slot[2:0]] == `KUL_BITMAP_EMPTY;
          end
          if (fail) begin
            // Abort before hashing; state stays as it was
            s_next.result.err = 1'b1;
            s_next.done = 1'b1;
            s_next.last_err = 8'h01;
          end else begin
            // Burn a use before the key is hashed, so a lost command costs one bit only
            if (CMD_IN != kul_pkg::KUL_CMD_READ && CMD_IN != kul_pkg::KUL_CMD_WRITE && !transport
                && CMD_IN != kul_pkg::KUL_CMD_VERIFY
                && (CMD_IN != kul_pkg::KUL_CMD_DERIVE || PARENT_USED_IN)) begin
              if (limited_15) begin
                s_next.slot15_use_bitmap = kul_clear_first128(s_reg.slot15_use_bitmap);
              end else if (limited_lo) begin
                s_next.remaining_uses_bitmap[slot[2:0]] =
                  kul_clear_first8(s_reg.remaining_uses_bitmap[slot[2:0]]);
              end
            end
            if (CMD_IN == kul_pkg::KUL_CMD_READ || CMD_IN == kul_pkg::KUL_CMD_WRITE) begin
              s_next.result.ok = 1'b1;
              s_next.done = 1'b1;
            end else begin
              s_next.state = kul_pkg::KUL_ST_WAIT;
            end
          end
        end
      end
      kul_pkg::KUL_ST_WAIT: begin
        if (HASH_DONE_IN) begin
          s_next.state = kul_pkg::KUL_ST_IDLE;
          s_next.done = 1'b1;
          if (s_reg.pend_copy) begin
            s_next.result.ok = RESP_MATCH_IN;
            s_next.result.err = !RESP_MATCH_IN;
            if (RESP_MATCH_IN) begin
              s_next.scratch_digest_reg.origin = 1'b1;
              s_next.scratch_digest_reg.data_cmd_origin = 1'b0;
              s_next.scratch_digest_reg.verify_restrict = 1'b0;
              s_next.scratch_digest_reg.valid = 1'b1;
            end
          end else begin
            s_next.result.ok = 1'b1;
            if (s_reg.pend_derive && !s_reg.pend_target[3]) begin
              // Only command refill path, beside register writes; slot 15 bitmap has none
              s_next.remaining_uses_bitmap[s_reg.pend_target[2:0]] = `KUL_BITMAP_FULL;
            end
          end
        end
      end
      default: begin
        s_next.state = kul_pkg::KUL_ST_IDLE;
      end
    endcase
    // Register port: personalization loads bitmaps, policy and scratch flags
    if (REG_WR_IN) begin
      unique case (REG_ADDR_IN)
        `KUL_REG_CTRL: begin
          s_next.one_shot_enable = REG_WDATA_IN[7:0];
          s_next.one_shot_enable_15 = REG_WDATA_IN[8];
        end
        // Caller must write legal low-order-run bytes only
        `KUL_REG_S15_LO: s_next.slot15_use_bitmap[63:0] = {REG_WDATA_IN, REG_WDATA_IN};
        `KUL_REG_S15_HI: s_next.slot15_use_bitmap[127:64] = {REG_WDATA_IN, REG_WDATA_IN};
        `KUL_REG_SCRATCH: s_next.scratch_digest_reg = kul_pkg::kul_scratch_t'(REG_WDATA_IN[3:0]);
        `KUL_REG_USES: s_next.remaining_uses_bitmap[REG_WDATA_IN[10:8]] = REG_WDATA_IN[7:0];
        `KUL_REG_POLICY: begin
          s_next.slot_write_policy = REG_WDATA_IN[15:0];
          s_next.read_auth_zero = REG_WDATA_IN[31:16];
        end
        default: begin
        end
      endcase
    end
    s_next.rdata = 32'h0;
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        `KUL_REG_CTRL: s_next.rdata = {23'h0, s_reg.one_shot_enable_15, s_reg.one_shot_enable};
        `KUL_REG_S15_LO: s_next.rdata = s_reg.slot15_use_bitmap[31:0];
        `KUL_REG_S15_HI: s_next.rdata = s_reg.slot15_use_bitmap[127:96];
        `KUL_REG_STATUS: s_next.rdata = {22'h0, s_reg.state, s_reg.last_err};
        `KUL_REG_SCRATCH: s_next.rdata = {28'h0, s_reg.scratch_digest_reg};
        `KUL_REG_USES: s_next.rdata = s_reg.remaining_uses_bitmap[3:0];
        `KUL_REG_POLICY: s_next.rdata = {s_reg.read_auth_zero, s_reg.slot_write_policy};
        default: s_next.rdata = 32'h0;
      endcase
    end
  end

  // ------------------------------
  // State register
  // ------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ------------------------------
  // Outputs
  // ------------------------------
  logic hash_start_reg;
  logic copy_load_reg;
  // Copy strobe registered so the output comes straight from a flop
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      hash_start_reg <= 1'b0;
      copy_load_reg <= 1'b0;
    end else begin
      hash_start_reg <= (s_reg.state == kul_pkg::KUL_ST_IDLE) && (s_next.state == kul_pkg::KUL_ST_WAIT);
      copy_load_reg <= s_next.done && s_next.result.copy && s_next.result.ok;
    end
  end

  assign REG_RDATA_OUT = s_reg.rdata;
  assign RESULT_VALID_OUT = s_reg.done;
  assign RESULT_OK_OUT = s_reg.result.ok;
  assign RESULT_ERR_OUT = s_reg.result.err;
  assign HASH_START_OUT = hash_start_reg;
  assign TRANSPORT_OUT = s_reg.result.transport;
  assign KEY_SLOT_OUT = s_reg.result.key_slot;
  assign HASH_SELECTOR_OUT = s_reg.result.hash_selector;
  assign COPY_LOAD_OUT = copy_load_reg;
  assign COPY_SLOT_OUT = s_reg.pend_target;
  assign SCRATCH_FLAGS_OUT = s_reg.scratch_digest_reg;
endmodule // kul_policy

// file: kul_policy_sva.sv
// Checker for the key-use policy block
module kul_policy_sva (
  input wire logic CLK_IN,
  input wire logic RSTN_IN,
  input wire logic CMD_VALID_IN,
  input wire kul_pkg::kul_cmd_t CMD_IN,
  input wire logic [15:0] SELECTOR_IN,
  input wire logic HASH_DONE_IN,
  input wire logic RESULT_VALID_OUT,
  input wire logic RESULT_OK_OUT,
  input wire logic RESULT_ERR_OUT,
  input wire logic HASH_START_OUT,
  input wire logic TRANSPORT_OUT,
  input wire logic [3:0] KEY_SLOT_OUT,
  input wire logic [15:0] HASH_SELECTOR_OUT,
  input wire logic COPY_LOAD_OUT,
  input wire logic [3:0] SCRATCH_FLAGS_OUT
);
  // ---
  // Accept tracking
  // ---
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic busy_reg;
  logic busy_next;
  logic acc;
  // Busy is only our view; a command in the result cycle is never sent
  assign acc = CMD_VALID_IN && !busy_reg;
  assign busy_next = acc | (busy_reg & ~RESULT_VALID_OUT);
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) busy_reg <= 1'b0;
    else busy_reg <= busy_next;
  end
  a_one_answer: assert property (acc |=> HASH_START_OUT != RESULT_VALID_OUT)
    else $error("accept did not give exactly one answer");
  a_ok_xor_err: assert property (RESULT_VALID_OUT |-> RESULT_OK_OUT ^ RESULT_ERR_OUT)
    else $error("result not ok xor error");
  a_transport_gate: assert property (acc && SELECTOR_IN[15] && CMD_IN != kul_pkg::KUL_CMD_DIGEST
    |=> RESULT_VALID_OUT && RESULT_ERR_OUT) else $error("transport key taken off digest");
  a_transport_go: assert property (acc && SELECTOR_IN[15] && CMD_IN == kul_pkg::KUL_CMD_DIGEST
    && !SCRATCH_FLAGS_OUT[3] |=> HASH_START_OUT && TRANSPORT_OUT) else $error("transport digest refused");
  a_slot_select: assert property (acc && !SELECTOR_IN[15] |=> KEY_SLOT_OUT == $past(SELECTOR_IN[3:0])
    && HASH_SELECTOR_OUT == $past(SELECTOR_IN) && !TRANSPORT_OUT) else $error("slot decode wrong");
  a_copy_result: assert property (COPY_LOAD_OUT |-> RESULT_VALID_OUT && RESULT_OK_OUT)
    else $error("copy without ok result");
  a_copy_flags: assert property (COPY_LOAD_OUT |-> ##[0:1] SCRATCH_FLAGS_OUT == 4'h9)
    else $error("scratch flags wrong after copy");
  a_done_answer: assert property (busy_reg && HASH_DONE_IN |=> RESULT_VALID_OUT)
    else $error("no result after hash done");
  a_start_pulse: assert property (HASH_START_OUT |=> !HASH_START_OUT [*2])
    else $error("hash start repeated");
endmodule // kul_policy_sva

bind kul_policy kul_policy_sva u_sva (.CLK_IN, .RSTN_IN, .CMD_VALID_IN, .CMD_IN, .SELECTOR_IN,
  .HASH_DONE_IN, .RESULT_VALID_OUT, .RESULT_OK_OUT, .RESULT_ERR_OUT, .HASH_START_OUT,
  .TRANSPORT_OUT, .KEY_SLOT_OUT, .HASH_SELECTOR_OUT, .COPY_LOAD_OUT, .SCRATCH_FLAGS_OUT);

// file: kul_hash_model.sv
// Hash engine stand-in answering the policy block
module kul_hash_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic start_in,
  input wire logic slow_in,
  input wire logic match_in,
  output logic done_out,
  output logic match_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Match only means something with done, so it is inverted elsewhere
  assign match_out = done_out ? match_in : ~match_in;
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 0;
      done_out <= 1'b0;
    end else begin
      done_out <= cnt == 1;
      if (start_in) cnt <= slow_in ? 9 : 2;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule // kul_hash_model

// file: kul_policy_tb.sv
// Self-checking bench for the key-use policy block
module kul_policy_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, cv = 1'b0, pu = 1'b0, sec = 1'b0, rw = 1'b0, rr = 1'b0;
  logic slow = 1'b0, match = 1'b1, rv, ok, er, hst, tr, cl, hd, rm;
  kul_pkg::kul_cmd_t c = kul_pkg::KUL_CMD_MAC;
  logic [15:0] sel = 16'h0000, hs;
  logic [3:0] tgt = 4'h0, ra = 4'h0, ks, cs, fl;
  logic [7:0] mode = 8'h00;
  logic [31:0] wd = 32'h0, rdo;
  int error_cnt = 0, checked = 0, seed = 91;
  logic [7:0] u [8] = '{default: 8'h00};
  logic [127:0] s15 = '0;
  kul_policy u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .CMD_VALID_IN(cv), .CMD_IN(c), .SELECTOR_IN(sel),
    .TARGET_IN(tgt), .PARENT_USED_IN(pu), .MODE_IN(mode), .SECONDARY_IN(sec), .HASH_DONE_IN(hd),
    .RESP_MATCH_IN(rm), .REG_ADDR_IN(ra), .REG_WDATA_IN(wd), .REG_WR_IN(rw), .REG_RD_IN(rr),
    .REG_RDATA_OUT(rdo), .RESULT_VALID_OUT(rv), .RESULT_OK_OUT(ok), .RESULT_ERR_OUT(er),
    .HASH_START_OUT(hst), .TRANSPORT_OUT(tr), .KEY_SLOT_OUT(ks), .HASH_SELECTOR_OUT(hs),
    .COPY_LOAD_OUT(cl), .COPY_SLOT_OUT(cs), .SCRATCH_FLAGS_OUT(fl));
  kul_hash_model u_hash (.clk_in(clk), .rstn_in(rstn), .start_in(hst), .slow_in(slow),
    .match_in(match), .done_out(hd), .match_out(rm));
  initial forever #50 clk = ~clk;
  // ---
  // Bus and command tasks
  // ---
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    rw <= 1'b1;
    @(posedge clk);
    rw <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    ra <= a;
    rr <= 1'b1;
    @(posedge clk);
    rr <= 1'b0;
    #1 chk(rdo, e);
  endtask
  task automatic cmd(input kul_pkg::kul_cmd_t k, input logic [15:0] s, input logic eok, input logic ecp);
    int n;
    @(posedge clk);
    cv <= 1'b1;
    c <= k;
    sel <= s;
    @(posedge clk);
    cv <= 1'b0;
    n = 0;
    #1;
    while (rv !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(ok, eok);
    chk(er, !eok);
    chk(cl, ecp);
    chk(hs, s);
    chk(ks, s[3:0]);
    chk(tr, s[15]);
  endtask
  task automatic use_key(input logic [3:0] s);
    logic e;
    logic [15:0] r;
    r = 16'($random(seed));
    r[15] = 1'b0;
    r[3:0] = s;
    if (s == 4'hF) begin
      e = s15 != 0;
      for (int i = 127; i >= 0; i--) if (s15[i]) begin
        s15[i] = 1'b0;
        break;
      end
    end else begin
      e = u[s[2:0]] != 0;
      for (int i = 7; i >= 0; i--) if (u[s[2:0]][i]) begin
        u[s[2:0]][i] = 1'b0;
        break;
      end
    end
    cmd(kul_pkg::KUL_CMD_MAC, r, e, 1'b0);
    rd(4'h5, {u[3], u[2], u[1], u[0]});
    rd(4'h2, s15[127:96]);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #400000;
    error_cnt++;
    final_report();
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rd(4'h0, 32'h0);
    wr(4'h0, 32'h108);
    wr(4'h5, 32'h303);
    u[3] = 8'h03;
    wr(4'h2, 32'h1);
    s15[127:64] = {32'h1, 32'h1};
    repeat (3) use_key(4'h3);
    cmd(kul_pkg::KUL_CMD_READ, 16'h0003, 1'b1, 1'b0);
    repeat (3) use_key(4'hF);
    wr(4'h6, 32'h2_0008);
    pu <= 1'b1;
    tgt <= 4'h3;
    cmd(kul_pkg::KUL_CMD_DERIVE, 16'h0003, 1'b0, 1'b0);
    pu <= 1'b0;
    cmd(kul_pkg::KUL_CMD_DERIVE, 16'h0003, 1'b1, 1'b0);
    u[3] = 8'hFF;
    use_key(4'h3);
    tgt <= 4'h4;
    cmd(kul_pkg::KUL_CMD_DERIVE, 16'h0004, 1'b0, 1'b0);
    cmd(kul_pkg::KUL_CMD_DIGEST, 16'h8003, 1'b1, 1'b0);
    cmd(kul_pkg::KUL_CMD_MAC, 16'h8003, 1'b0, 1'b0);
    mode <= 8'h01;
    sec <= 1'b1;
    slow <= 1'b1;
    cmd(kul_pkg::KUL_CMD_VERIFY, 16'h0000, 1'b1, 1'b1);
    chk(cs, 32'h1);
    chk(fl, 32'h9);
    cmd(kul_pkg::KUL_CMD_VERIFY, 16'h0000, 1'b1, 1'b0);
    mode <= 8'h05;
    sec <= 1'b0;
    cmd(kul_pkg::KUL_CMD_VERIFY, 16'h0000, 1'b1, 1'b0);
    sec <= 1'b1;
    cmd(kul_pkg::KUL_CMD_VERIFY, 16'h0000, 1'b1, 1'b1);
    match <= 1'b0;
    cmd(kul_pkg::KUL_CMD_VERIFY, 16'h0000, 1'b0, 1'b0);
    cmd(kul_pkg::KUL_CMD_DIGEST, 16'h8003, 1'b0, 1'b0);
    final_report();
  end
endmodule // kul_policy_tb
